// ### rtl/imscg_defines.svh
`ifndef IMSCG_DEFINES_SVH
`define IMSCG_DEFINES_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define IMSCG_OFS_CTRL     8'h00
`define IMSCG_OFS_GATE     8'h04
`define IMSCG_OFS_STAT     8'h08
`define IMSCG_OFS_IRQ      8'h0c
`define IMSCG_CTRL_DEEP    0
`define IMSCG_CTRL_RST     1'h0
`define IMSCG_GATE_RST     15'h0000
`define IMSCG_NUM_PCLK     15

// ----------------------------------------
// peripheral clock gate bit positions
// ----------------------------------------
`define IMSCG_PCLK_CONV    0
`define IMSCG_PCLK_SSP     1
`define IMSCG_PCLK_UART    2
`define IMSCG_PCLK_TIM0    3
`define IMSCG_PCLK_TIM1    4
`define IMSCG_PCLK_PWM0    5
`define IMSCG_PCLK_WDOG    13
`define IMSCG_PCLK_RNG     14

// ----------------------------------------
// interrupt lines and vectors
// ----------------------------------------
`define IMSCG_NUM_IRQ      26
`define IMSCG_IRQ_DMA      11
`define IMSCG_IRQ_CONV     23
`define IMSCG_IRQ_NET      24
`define IMSCG_IRQ_EXT      25
`define IMSCG_IRQ_RSVD     32'hfc40_0000
`define IMSCG_VEC_BASE     32'h0000_0040
`define IMSCG_VEC_NMI      32'h0000_0008

`endif

// ### rtl/imscg_pkg.sv
package imscg_pkg;

  typedef enum logic [1:0] {
    st_run,
    st_sleep,
    st_restart,
    st_resume
  } imscg_state_type;

  typedef struct packed {
    logic [1:0] ssp;
    logic [2:0] uart;
    logic [1:0] i2c;
    logic [3:0] gpio;
    logic [5:0] dma_done;
    logic [1:0] dualtimer;
    logic [7:0] pwm;
    logic       converter_acq_end;
    logic       network_offload_irq;
    logic       external_pin_irq;
    logic       watchdog;
  } imscg_src_type;

  typedef struct packed {
    logic cpu;
    logic apb;
    logic ahb;
    logic mem;
  } imscg_clk_en_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } imscg_wb_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } imscg_wb_rsp_type;

endpackage

// ### rtl/imscg_irq_map.sv
`timescale 1ns/1ps
`default_nettype none
`include "imscg_defines.svh"
module imscg_irq_map (
  input  wire  logic                    mclk_i,
  input  wire  logic                    reset_n_i,
  input  wire  imscg_pkg::imscg_src_type src_i,
  output logic [31:0]                   irq_o,
  output logic                          nmi_o,
  output logic [31:0]                   vector_o
);
  import imscg_pkg::*;

  // ----------------------------------------
  // source to line mapping
  // ----------------------------------------
  wire logic [31:0] raw;
  wire logic        dma_any;
  wire logic [31:0] rsvd;
  assign dma_any = |src_i.dma_done[5:1];
  assign rsvd    = `IMSCG_IRQ_RSVD;
  assign raw = {6'h00, src_i.external_pin_irq, src_i.network_offload_irq,
                src_i.converter_acq_end, 1'b0, src_i.pwm, src_i.dualtimer,
                dma_any, src_i.gpio, src_i.i2c, src_i.uart, src_i.ssp};

  function automatic logic [4:0] first_set(input logic [31:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  wire logic [31:0] vec_d;
  assign vec_d = src_i.watchdog ? `IMSCG_VEC_NMI :
                 `IMSCG_VEC_BASE + {25'h0, first_set(raw & ~rsvd), 2'b00};

  genvar n;
  generate
    for (n = 0; n < 32; n++) begin : g_line
      always_ff @(posedge mclk_i) begin
        if (!reset_n_i) irq_o[n] <= 1'b0;
        else            irq_o[n] <= raw[n] & ~rsvd[n];
      end
    end
  endgenerate

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      nmi_o    <= 1'b0;
      vector_o <= `IMSCG_VEC_BASE;
    end else begin
      nmi_o    <= src_i.watchdog;
      vector_o <= vec_d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_reserved_quiet: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (irq_o & `IMSCG_IRQ_RSVD) == 32'h0000_0000)
    else $error("reserved irq line asserted");
  a_dma_combine: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ##1 irq_o[`IMSCG_IRQ_DMA] == $past(|src_i.dma_done[5:1]))
    else $error("dma line does not follow channels one to five");
  a_line_place: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    src_i.converter_acq_end && src_i.external_pin_irq
    |=> irq_o[`IMSCG_IRQ_CONV] && irq_o[`IMSCG_IRQ_EXT])
    else $error("converter or pin line misplaced");
  a_nmi_vector: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    src_i.watchdog |=> nmi_o && vector_o == `IMSCG_VEC_NMI)
    else $error("watchdog not on nmi");
endmodule
`default_nettype wire

// ### rtl/imscg_clk_gate.sv
`timescale 1ns/1ps
`default_nettype none
`include "imscg_defines.svh"
module imscg_clk_gate (
  input  wire  logic                         mclk_i,
  input  wire  logic                         reset_n_i,
  input  wire  imscg_pkg::imscg_state_type   state_i,
  input  wire  logic                         deep_i,
  input  wire  logic [`IMSCG_NUM_PCLK-1:0]   gate_i,
  output imscg_pkg::imscg_clk_en_type        clk_en_o,
  output logic [`IMSCG_NUM_PCLK-1:0]         pclk_en_o
);
  import imscg_pkg::*;

  // enables feed latch-based gating cells, never raw clock logic
  wire logic asleep;
  wire logic bus_on;
  assign asleep = (state_i == st_sleep);
  assign bus_on = !(asleep && deep_i);

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      clk_en_o <= '{cpu: 1'b1, apb: 1'b1, ahb: 1'b1, mem: 1'b1};
    end else begin
      clk_en_o <= '{cpu: !asleep, apb: bus_on,
                    ahb: bus_on, mem: bus_on};
    end
  end

  genvar g;
  generate
    for (g = 0; g < `IMSCG_NUM_PCLK; g++) begin : g_pclk
      always_ff @(posedge mclk_i) begin
        if (!reset_n_i) pclk_en_o[g] <= 1'b1;
        else            pclk_en_o[g] <= !gate_i[g];
      end
    end
  endgenerate

  a_light_sleep: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    state_i == st_sleep && !deep_i
    |=> !clk_en_o.cpu && clk_en_o.apb && clk_en_o.ahb && clk_en_o.mem)
    else $error("light sleep gated the wrong clocks");
  a_deep_sleep: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    state_i == st_sleep && deep_i |=> clk_en_o == 4'h0)
    else $error("deep sleep left a clock running");
  a_pclk_follow: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ##1 pclk_en_o == ~$past(gate_i))
    else $error("peripheral enable does not follow gate register");
endmodule
`default_nettype wire

// ### rtl/imscg_top.sv
// Notes on behaviour
// - Twenty-five usable lines, one nmi line fed by the watchdog, one wake.
// - Line n vectors to 0x40 plus 4n, nmi to 0x08; 22 and 26-31 stay low.
// - Dma channels one to five share line eleven.
// - Converter end on 23, network offload on 24, external pin on 25.
// - A finished dma transfer raises a wake event toward the core.
// - Reset leaves run mode with every clock on; no power-off mode exists.
// - Light sleep stops only the processor clock.
// - Deep sleep stops processor, both bus and memory clocks.
// - Wait-for-interrupt wakes on any interrupt, wait-for-event on an event.
// - In run mode software can stop each peripheral clock on its own.
`timescale 1ns/1ps
`default_nettype none
`include "imscg_defines.svh"
module imscg_top (
  input  wire  logic                       mclk_i,
  input  wire  logic                       reset_n_i,
  input  wire  imscg_pkg::imscg_wb_req_type wb_req_i,
  output imscg_pkg::imscg_wb_rsp_type      wb_rsp_o,
  input  wire  imscg_pkg::imscg_src_type   src_i,
  input  wire  logic                       wait_interrupt_instr_i,
  input  wire  logic                       wait_event_instr_i,
  output logic [31:0]                      irq_o,
  output logic                             nmi_o,
  output logic [31:0]                      vector_o,
  output logic                             wake_event_o,
  output logic                             core_resume_o,
  output imscg_pkg::imscg_clk_en_type      clk_en_o,
  output logic [`IMSCG_NUM_PCLK-1:0]       pclk_en_o
);
  import imscg_pkg::*;

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic                       ack_q;
  logic [31:0]                rdat_q;
  logic                       deep_sel_q;
  logic [`IMSCG_NUM_PCLK-1:0] gate_q;
  logic                       deep_lat_q;
  logic                       wfe_q;
  logic                       evt_q;
  imscg_state_type            state_q;
  imscg_state_type            state_d;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire logic        req;
  wire logic        wr;
  wire logic        hit_ctrl;
  wire logic        hit_gate;
  wire logic        hit_stat;
  wire logic        hit_irq;
  wire logic [31:0] stat_word;
  wire logic [31:0] rd_mux;

  assign req      = wb_req_i.cyc && wb_req_i.stb && !ack_q;
  assign wr       = req && wb_req_i.we;
  assign hit_ctrl = (wb_req_i.adr == `IMSCG_OFS_CTRL);
  assign hit_gate = (wb_req_i.adr == `IMSCG_OFS_GATE);
  assign hit_stat = (wb_req_i.adr == `IMSCG_OFS_STAT);
  assign hit_irq  = (wb_req_i.adr == `IMSCG_OFS_IRQ);

  assign stat_word = {24'h000000, clk_en_o, evt_q, deep_lat_q, state_q};
  // unmapped offsets answer with zero so software never stalls the bus
  assign rd_mux = hit_ctrl ? {31'h0, deep_sel_q} :
                  hit_gate ? {17'h0, gate_q} :
                  hit_stat ? stat_word :
                  hit_irq  ? irq_o : 32'h0000_0000;

  assign wb_rsp_o = '{ack: ack_q, dat: rdat_q};

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= req;
      rdat_q <= req ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  wire logic wr_ctrl;
  wire logic wr_gate_lo;
  wire logic wr_gate_hi;
  assign wr_ctrl    = wr && hit_ctrl && wb_req_i.sel[0];
  assign wr_gate_lo = wr && hit_gate && wb_req_i.sel[0];
  assign wr_gate_hi = wr && hit_gate && wb_req_i.sel[1];

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      deep_sel_q <= `IMSCG_CTRL_RST;
      gate_q     <= `IMSCG_GATE_RST;
    end else begin
      if (wr_ctrl)    deep_sel_q   <= wb_req_i.dat[`IMSCG_CTRL_DEEP];
      if (wr_gate_lo) gate_q[7:0]  <= wb_req_i.dat[7:0];
      if (wr_gate_hi) gate_q[14:8] <= wb_req_i.dat[14:8];
    end
  end

  // ----------------------------------------
  // interrupt routing
  // ----------------------------------------
  imscg_irq_map u_irq (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .src_i     (src_i),
    .irq_o     (irq_o),
    .nmi_o     (nmi_o),
    .vector_o  (vector_o)
  );

  // ----------------------------------------
  // wake event
  // ----------------------------------------
  wire logic dma_fin;
  wire logic any_irq;
  wire logic evt_take;
  assign dma_fin = |src_i.dma_done;
  assign any_irq = (|irq_o) || nmi_o;

  // a latched event lets a later wait-for-event fall straight through
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      wake_event_o <= 1'b0;
      evt_q        <= 1'b0;
    end else begin
      wake_event_o <= dma_fin;
      if (wake_event_o)  evt_q <= 1'b1;
      else if (evt_take) evt_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // sleep sequencer
  // ----------------------------------------
  wire logic enter;
  wire logic wake_ok;
  assign enter   = wait_interrupt_instr_i || wait_event_instr_i;
  assign wake_ok = wfe_q ? evt_q : any_irq;
  assign evt_take = (state_q == st_run && wait_event_instr_i && evt_q) ||
                    (state_q == st_sleep && wfe_q && evt_q);

  always_comb begin
    state_d = state_q;
    case (state_q)
      st_run: begin
        if (wait_event_instr_i && evt_q) state_d = st_resume;
        else if (enter)                  state_d = st_sleep;
      end
      st_sleep: begin
        if (wake_ok) state_d = st_restart;
      end
      st_restart: begin
        state_d = st_resume;
      end
      st_resume: begin
        state_d = st_run;
      end
      default: begin
        state_d = st_run;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      state_q    <= st_run;
      deep_lat_q <= 1'b0;
      wfe_q      <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q == st_run && enter) begin
        deep_lat_q <= deep_sel_q;
        wfe_q      <= wait_event_instr_i && !wait_interrupt_instr_i;
      end
    end
  end

  // resume after the restart cycle has put the enables back, or straight from run on a latched event
  assign core_resume_o = (state_q == st_resume);

  imscg_clk_gate u_gate (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .state_i   (state_q),
    .deep_i    (deep_lat_q),
    .gate_i    (gate_q),
    .clk_en_o  (clk_en_o),
    .pclk_en_o (pclk_en_o)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_reset_run: assert property (@(posedge mclk_i)
    !reset_n_i |=> state_q == st_run && clk_en_o == 4'hf
                   && (&pclk_en_o))
    else $error("reset did not leave run mode with clocks on");
  a_wfi_wake: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    state_q == st_sleep && !wfe_q && any_irq
    |=> state_q == st_restart ##1 core_resume_o)
    else $error("interrupt did not wake the core");
  a_wfe_wake: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    state_q == st_sleep && wfe_q && dma_fin
    |-> ##[1:3] state_q == st_restart)
    else $error("dma event did not wake the core");
  a_resume_clocks: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    core_resume_o |-> clk_en_o == 4'hf)
    else $error("core resumed with a clock still stopped");
  a_ack_single: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    wb_req_i.cyc && wb_req_i.stb && !ack_q |=> ack_q ##1 !ack_q)
    else $error("bus answer not one cycle");
  a_evt_kept: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    wake_event_o |=> evt_q)
    else $error("wake event lost");

  c_light_sleep: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    state_q == st_sleep && !deep_lat_q ##1 state_q == st_restart);
  c_deep_sleep: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    state_q == st_sleep && deep_lat_q && wfe_q);
  c_gate_write: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
    wr_gate_lo ##2 !pclk_en_o[`IMSCG_PCLK_CONV]);
endmodule
`default_nettype wire

// ### dv/imscg_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module imscg_core_model (
  input  wire logic mclk_i,
  input  wire logic reset_n_i,
  input  wire logic go_wfi_i,
  input  wire logic go_wfe_i,
  input  wire logic core_resume_i,
  output logic      wait_interrupt_instr_o,
  output logic      wait_event_instr_o,
  output logic      asleep_o
);
  // ----------------------------------------
  // wait instruction, then stall
  // ----------------------------------------
  // a stalled core issues nothing until the resume pulse
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      wait_interrupt_instr_o <= 1'h0;
      wait_event_instr_o     <= 1'h0;
      asleep_o               <= 1'h0;
    end else begin
      wait_interrupt_instr_o <= go_wfi_i & ~asleep_o;
      wait_event_instr_o     <= go_wfe_i & ~asleep_o;
      if (core_resume_i) begin
        asleep_o <= 1'h0;
      end else if (go_wfi_i | go_wfe_i) begin
        asleep_o <= 1'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/imscg_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module imscg_top_tb_top;
  import imscg_pkg::*;
  typedef struct packed {
    logic [30:0] src;
    logic [31:0] irq;
    logic        nmi;
    logic [31:0] vec;
    logic        wake;
  } imscg_row_type;

  logic             mclk_i;
  logic             reset_n_i;
  imscg_wb_req_type wb_req;
  imscg_wb_rsp_type wb_rsp;
  imscg_src_type    src;
  logic             go_wfi, go_wfe, wait_interrupt_instr, wait_event_instr, asleep;
  logic [31:0]      irq, vec, rdat;
  logic             nmi, wake, resume;
  imscg_clk_en_type clk_en;
  logic [14:0]      pclk_en;
  int               miscompares = 0;
  int               checks = 0;
  int               cycles = 0;

  // dma channel 0 wakes but has no interrupt line
  imscg_row_type rows [13] = '{
    '{31'h2000_0000, 32'h1, 1'h0, 32'h40, 1'h0},
    '{31'h0000_8000, 32'h800, 1'h0, 32'h6c, 1'h1},
    '{31'h0000_4000, 32'h0, 1'h0, 32'h40, 1'h1},
    '{31'h0008_0000, 32'h800, 1'h0, 32'h6c, 1'h1},
    '{31'h8, 32'h0080_0000, 1'h0, 32'h9c, 1'h0},
    '{31'h4, 32'h0100_0000, 1'h0, 32'ha0, 1'h0},
    '{31'h2, 32'h0200_0000, 1'h0, 32'ha4, 1'h0},
    '{31'h1, 32'h0, 1'h1, 32'h8, 1'h0},
    '{31'h800, 32'h0020_0000, 1'h0, 32'h94, 1'h0},
    '{31'h0080_0000, 32'h400, 1'h0, 32'h68, 1'h0},
    '{31'h0200_2000, 32'h2040, 1'h0, 32'h58, 1'h0},
    '{31'h7fff_ffff, 32'h03bf_ffff, 1'h1, 32'h8, 1'h1},
    '{31'h0, 32'h0, 1'h0, 32'h40, 1'h0}
  };

  imscg_top dut_u (
    .mclk_i                 (mclk_i),
    .reset_n_i              (reset_n_i),
    .wb_req_i               (wb_req),
    .wb_rsp_o               (wb_rsp),
    .src_i                  (src),
    .wait_interrupt_instr_i (wait_interrupt_instr),
    .wait_event_instr_i     (wait_event_instr),
    .irq_o                  (irq),
    .nmi_o                  (nmi),
    .vector_o               (vec),
    .wake_event_o           (wake),
    .core_resume_o          (resume),
    .clk_en_o               (clk_en),
    .pclk_en_o              (pclk_en)
  );

  imscg_core_model core_u (
    .mclk_i                 (mclk_i),
    .reset_n_i              (reset_n_i),
    .go_wfi_i               (go_wfi),
    .go_wfe_i               (go_wfe),
    .core_resume_i          (resume),
    .wait_interrupt_instr_o (wait_interrupt_instr),
    .wait_event_instr_o     (wait_event_instr),
    .asleep_o               (asleep)
  );

  // ----------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------
  initial begin
    mclk_i = 1'h0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic finish_test;
    if (miscompares == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  // classic cycle: hold until ack is sampled, then release
  task automatic wb_io(input logic we, input logic [7:0] adr,
                       input logic [31:0] wdat, output logic [31:0] rd);
    @(posedge mclk_i);
    wb_req <= {1'h1, 1'h1, we, 4'hf, adr, wdat};
    // only the bench timeout ends this wait
    do begin
      @(posedge mclk_i);
    end while (wb_rsp.ack !== 1'h1);
    rd = wb_rsp.dat;
    wb_req <= '0;
  endtask

  task automatic sleep(input logic ev);
    @(posedge mclk_i);
    go_wfe <= ev;
    go_wfi <= ~ev;
    @(posedge mclk_i);
    go_wfe <= 1'h0;
    go_wfi <= 1'h0;
  endtask

  task automatic wait_resume(input int lim);
    // look at the current cycle first: a latched event resumes at once
    for (int n = 0; n < lim; n++) begin
      #1;
      if (resume === 1'h1) break;
      @(posedge mclk_i);
    end
    check({31'h0, resume}, 32'h1);
    check({28'h0, clk_en}, 32'hf);
  endtask

  task automatic set_src(input logic [30:0] v);
    @(posedge mclk_i);
    src <= v;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset_n_i = 1'h0;
    wb_req = '0;
    src = '0;
    go_wfi = 1'h0;
    go_wfe = 1'h0;
    repeat (8) @(posedge mclk_i);
    reset_n_i <= 1'h1;
    #1;
    check({28'h0, clk_en}, 32'hf);
    check({17'h0, pclk_en}, 32'h7fff);
    check(vec, 32'h40);
    foreach (rows[i]) begin
      set_src(rows[i].src);
      tick(2);
      check(irq, rows[i].irq);
      check({31'h0, nmi}, {31'h0, rows[i].nmi});
      check(vec, rows[i].vec);
      check({31'h0, wake}, {31'h0, rows[i].wake});
    end
    for (int b = 0; b < 15; b++) begin
      wb_io(1'h1, 8'h04, 32'h1 << b, rdat);
      tick(1);
      check({17'h0, pclk_en}, {17'h0, ~(15'h1 << b)});
    end
    wb_io(1'h0, 8'h04, 32'h0, rdat);
    check(rdat, 32'h4000);
    wb_io(1'h0, 8'h10, 32'h0, rdat);
    check(rdat, 32'h0);
    wb_io(1'h1, 8'h04, 32'h0, rdat);
    // event left latched by the table: no sleep at all
    sleep(1'h1);
    wait_resume(6);
    wb_io(1'h1, 8'h00, 32'h1, rdat);
    wb_io(1'h0, 8'h00, 32'h0, rdat);
    check(rdat, 32'h1);
    sleep(1'h1);
    tick(3);
    check({28'h0, clk_en}, 32'h0);
    set_src(31'h2);
    tick(6);
    check({28'h0, clk_en}, 32'h0);
    set_src(31'h0001_0000);
    wait_resume(8);
    set_src(31'h0);
    wb_io(1'h1, 8'h00, 32'h0, rdat);
    sleep(1'h0);
    tick(3);
    check({28'h0, clk_en}, 32'h7);
    set_src(31'h1);
    wait_resume(8);
    set_src(31'h0);
    wb_io(1'h1, 8'h04, 32'h7fff, rdat);
    wb_io(1'h1, 8'h00, 32'h1, rdat);
    sleep(1'h0);
    tick(3);
    check({28'h0, clk_en}, 32'h0);
    @(posedge mclk_i);
    reset_n_i <= 1'h0;
    tick(2);
    check({28'h0, clk_en}, 32'hf);
    check({17'h0, pclk_en}, 32'h7fff);
    @(posedge mclk_i);
    reset_n_i <= 1'h1;
    wb_io(1'h0, 8'h00, 32'h0, rdat);
    check(rdat, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
